// ---- rtl/sblc_pkg.sv ----
package sblc_pkg;

  // ---------------------------------------------------------------------
  // Strap bit positions in the latch and the status word.
  // ---------------------------------------------------------------------
  localparam int STRAP_W = 5;
  localparam int BIT_LDO = 0;
  localparam int BIT_PRIMARY = 1;
  localparam int BIT_SECONDARY = 2;
  localparam int BIT_LOG_TIMING = 3;
  localparam int BIT_SDIO_TIMING = 4;

  // Weak pull directions applied while the pins act as straps.
  localparam logic [4:0] PULL_UP_MASK = 5'h1a;
  localparam logic [4:0] PULL_DOWN_MASK = 5'h05;
  localparam logic [4:0] STRAP_RESET = 5'h00;

  // ---------------------------------------------------------------------
  // Register map, byte addresses on the APB.
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STRAP_STATUS = 12'h000;
  localparam logic [11:0] OFS_OVERRIDE = 12'h004;
  localparam logic [11:0] OFS_BOOT_STATUS = 12'h008;

  // Override register fields.
  localparam int OVR_LDO_EN = 0;
  localparam int OVR_LDO_VAL = 1;
  localparam int OVR_SDIO_EN = 2;
  localparam int OVR_SDIO_LO = 3;
  localparam int OVR_SDIO_HI = 4;
  localparam int OVR_W = 5;
  localparam logic [4:0] OVR_RESET = 5'h00;

  // ---------------------------------------------------------------------
  // Timing: settle time after reset release before the straps are taken.
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // Boot source decoded from the straps.
  typedef enum logic [1:0] {
    BOOT_PENDING = 2'b00,
    BOOT_SPI_FLASH = 2'b01,
    BOOT_DOWNLOAD = 2'b10,
    BOOT_RESERVED = 2'b11
  } sblc_boot_type;

  // Phase of the strap sequence.
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN = 2'b10
  } sblc_state_type;

endpackage

// ---- rtl/sblc_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for levels coming from pins.
module sblc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ---- rtl/sblc_top.sv ----
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Sample five strap levels at every system reset.
// - Latched straps hold until power loss; here reset clears them and a re-enable takes them again.
// - Software reads all five latched bits.
// - Weak pulls on straps during reset phase.
// - After reset pins return to normal function.
// - Primary one: flash boot; both zero: download.
// - LDO strap zero 3.3 V, one 1.8 V.
// - Log strap gates boot log on UART.
// - Log and timing straps pick SDIO edges.
// - Firmware may override LDO and SDIO settings.
// - Module enable high enables the block.
module sblc_top
  import sblc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic module_enable,
  input wire logic ldo_voltage_strap,
  input wire logic primary_boot_strap,
  input wire logic secondary_boot_strap,
  input wire logic log_and_timing_strap,
  input wire logic sdio_timing_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [4:0] strap_pull_up_en,
  output logic [4:0] strap_pull_down_en,
  output logic strap_role,
  output logic boot_done,
  output logic [1:0] boot_source,
  output logic ldo_select_1v8,
  output logic uart0_log_enable,
  output logic sdio_input_rising,
  output logic sdio_output_rising
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------

  logic [STRAP_W-1:0] strap_pins;
  logic [STRAP_W-1:0] strap_sync;
  logic enable_sync;

  // Gather the strap pins in latch bit order.
  always_comb begin
    strap_pins = STRAP_RESET;
    strap_pins[BIT_LDO] = ldo_voltage_strap;
    strap_pins[BIT_PRIMARY] = primary_boot_strap;
    strap_pins[BIT_SECONDARY] = secondary_boot_strap;
    strap_pins[BIT_LOG_TIMING] = log_and_timing_strap;
    strap_pins[BIT_SDIO_TIMING] = sdio_timing_strap;
  end

  // Every pin passes two flops before any logic looks at it.
  sblc_sync2 #(
    .WIDTH(STRAP_W + 1)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({module_enable, strap_pins}),
    .sync_out({enable_sync, strap_sync})
  );

  // ---------------------------------------------------------------------
  // Strap sequence
  // ---------------------------------------------------------------------

  sblc_state_type state_q;
  sblc_state_type state_d;
  logic [CNT_W-1:0] settle_q;
  logic [CNT_W-1:0] settle_d;
  logic [STRAP_W-1:0] latch_q;
  logic [STRAP_W-1:0] latch_d;

  // The pulls stay on until the synchronised pins have settled and the
  // straps are taken; only then are the pins handed back to function.
  // A low module enable restarts the sequence at the settle phase; the latch and the override keep their values.
  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    latch_d = latch_q;
    if (!enable_sync) begin
      state_d = ST_SETTLE;
      settle_d = '0;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          if (settle_q == CNT_W'(SETTLE_CYCLES - 1)) begin
            state_d = ST_LATCH;
          end else begin
            settle_d = settle_q + CNT_W'(1);
          end
        end
        ST_LATCH: begin
          latch_d = strap_sync;
          state_d = ST_RUN;
        end
        ST_RUN: begin
          latch_d = latch_q;
        end
        default: begin
          state_d = ST_SETTLE;
          settle_d = '0;
        end
      endcase
    end
  end

  // Reset puts the sequence back at the start of the strap phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_SETTLE;
      settle_q <= '0;
      latch_q <= STRAP_RESET;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      latch_q <= latch_d;
    end
  end

  // ---------------------------------------------------------------------
  // APB register slave
  // ---------------------------------------------------------------------

  logic [OVR_W-1:0] ovr_q;
  logic [OVR_W-1:0] ovr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic access;
  logic hit;
  logic [31:0] read_word;
  sblc_boot_type boot_q;

  // A transfer completes one cycle into its access phase.
  assign access = psel & penable & ~pready_q;

  // Address decode and read multiplexer.
  always_comb begin
    hit = 1'b1;
    read_word = 32'h0000_0000;
    case (paddr)
      OFS_STRAP_STATUS: begin
        read_word[STRAP_W-1:0] = latch_q;
      end
      OFS_OVERRIDE: begin
        read_word[OVR_W-1:0] = ovr_q;
      end
      OFS_BOOT_STATUS: begin
        read_word[1:0] = boot_q;
        read_word[3:2] = state_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Override writes count only once boot is done; read-only registers
  // ignore writes; an unmapped address answers with an error.
  always_comb begin
    ovr_d = ovr_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (access) begin
      pready_d = 1'b1;
      pslverr_d = ~hit;
      prdata_d = pwrite ? 32'h0000_0000 : read_word;
      if (pwrite && paddr == OFS_OVERRIDE && state_q == ST_RUN) begin
        ovr_d = pwdata[OVR_W-1:0];
      end
    end
  end

  // Bus registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q <= OVR_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------------
  // Pin role and weak pulls
  // ---------------------------------------------------------------------

  logic [4:0] pu_q;
  logic [4:0] pu_d;
  logic [4:0] pd_q;
  logic [4:0] pd_d;
  logic role_q;
  logic role_d;
  logic done_q;
  logic done_d;

  // The pins keep their strap role, with the weak pulls on, until the
  // straps are taken; from that edge on they serve their normal function.
  // The pulls and the role flag move together, so a pin never floats
  // while the latch still waits for it.
  always_comb begin
    role_d = (state_d != ST_RUN);
    pu_d = role_d ? PULL_UP_MASK : 5'h00;
    pd_d = role_d ? PULL_DOWN_MASK : 5'h00;
    done_d = (state_d == ST_RUN);
  end

  // During reset the pins are in their strap role with the pulls on, so
  // an undriven strap settles to its default level before it is taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q <= PULL_UP_MASK;
      pd_q <= PULL_DOWN_MASK;
      role_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      pu_q <= pu_d;
      pd_q <= pd_d;
      role_q <= role_d;
      done_q <= done_d;
    end
  end

  // ---------------------------------------------------------------------
  // Boot source and boot log
  // ---------------------------------------------------------------------

  sblc_boot_type boot_d;
  logic log_q;
  logic log_d;

  // The boot source is pending until the straps are taken; the reserved
  // combination selects neither defined boot mode, so firmware can tell
  // a miswired board from a real download request.
  always_comb begin
    if (!done_d) begin
      boot_d = BOOT_PENDING;
    end else if (latch_d[BIT_PRIMARY]) begin
      boot_d = BOOT_SPI_FLASH;
    end else if (!latch_d[BIT_SECONDARY]) begin
      boot_d = BOOT_DOWNLOAD;
    end else begin
      boot_d = BOOT_RESERVED;
    end
    log_d = done_d & latch_d[BIT_LOG_TIMING];
  end

  // Nothing is decoded while the straps are still open, so the boot
  // source reads as pending and the log line stays silent.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= BOOT_PENDING;
      log_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      log_q <= log_d;
    end
  end

  // ---------------------------------------------------------------------
  // Supply and SDIO edge selects
  // ---------------------------------------------------------------------

  logic ldo_q;
  logic ldo_d;
  logic in_rise_q;
  logic in_rise_d;
  logic out_rise_q;
  logic out_rise_d;
  logic [1:0] edges;

  // Supply and edge selects follow the latch unless firmware has set the
  // matching override enable; the boot log line has no override.
  // The edge pair is ordered {input rising, output rising}.
  always_comb begin
    ldo_d = ovr_d[OVR_LDO_EN] ? ovr_d[OVR_LDO_VAL]
                              : latch_d[BIT_LDO];
    edges = {latch_d[BIT_LOG_TIMING], latch_d[BIT_SDIO_TIMING]};
    if (ovr_d[OVR_SDIO_EN]) begin
      edges = ovr_d[OVR_SDIO_HI:OVR_SDIO_LO];
    end
    in_rise_d = edges[1];
    out_rise_d = edges[0];
  end

  // A supply select of zero is the 3.3 V setting, which is also the safe
  // choice while the straps are still open.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo_q <= 1'b0;
      in_rise_q <= 1'b0;
      out_rise_q <= 1'b0;
    end else begin
      ldo_q <= ldo_d;
      in_rise_q <= in_rise_d;
      out_rise_q <= out_rise_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Every output is taken straight from a flop.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign strap_pull_up_en = pu_q;
  assign strap_pull_down_en = pd_q;
  assign strap_role = role_q;
  assign boot_done = done_q;
  assign boot_source = boot_q;
  assign ldo_select_1v8 = ldo_q;
  assign uart0_log_enable = log_q;
  assign sdio_input_rising = in_rise_q;
  assign sdio_output_rising = out_rise_q;

endmodule

`default_nettype wire

// ---- bench/sblc_board.sv ----
`timescale 1ns/100ps
`default_nettype none

// Board side of the straps: host GPIOs where driven (a driven pin 0 reads low), else the weak pulls, else a floating level.
module sblc_board (
  input wire logic pclk,
  input wire logic [4:0] pull_up,
  input wire logic [4:0] pull_dn,
  input wire logic [4:0] drv_en,
  input wire logic [4:0] drv_val,
  output logic [4:0] pins
);
  logic float_q = 1'b0;

  // A floating pin shows a level that flips every cycle.
  always @(posedge pclk) begin
    float_q <= !float_q;
  end

  // Resolves each pin from host drive, pull or nothing.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (drv_en[i]) begin
        pins[i] = drv_val[i] && i != 0;
      end else if (pull_up[i]) begin
        pins[i] = 1'b1;
      end else if (pull_dn[i]) begin
        pins[i] = 1'b0;
      end else begin
        pins[i] = float_q;
      end
    end
  end
endmodule

`default_nettype wire

// ---- bench/sblc_top_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

// Watches the strap block at its ports.
module sblc_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic module_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] strap_pull_up_en,
  input wire logic [4:0] strap_pull_down_en,
  input wire logic strap_role,
  input wire logic boot_done,
  input wire logic [1:0] boot_source,
  input wire logic ldo_select_1v8,
  input wire logic uart0_log_enable,
  input wire logic sdio_input_rising,
  input wire logic sdio_output_rising
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_ovr;
    s_done and pwrite && paddr == 12'h004 && boot_done;
  endsequence

  property p_wait;
    s_setup |-> !pready ##1 pready;
  endproperty
  property p_err;
    s_done and !(paddr inside {12'h000, 12'h004, 12'h008})
      |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  property p_boot;
    s_done and !pwrite && paddr == 12'h000 && boot_done && $past(boot_done)
      |-> boot_source == (prdata[1] ? 2'b01 : prdata[2] ? 2'b11 : 2'b10)
      && uart0_log_enable == prdata[3];
  endproperty
  property p_pon;
    strap_role |-> strap_pull_up_en == 5'h1a && strap_pull_down_en == 5'h05;
  endproperty
  property p_poff;
    !strap_role |-> boot_done && (strap_pull_up_en | strap_pull_down_en) == 0;
  endproperty
  property p_hold;
    boot_done && $past(boot_done)
      |-> $stable(boot_source) && $stable(uart0_log_enable);
  endproperty
  property p_start;
    $rose(presetn) && module_enable |-> ##[5:9] boot_done;
  endproperty
  property p_dis;
    $fell(module_enable) |-> ##[1:4] (strap_role && !boot_done);
  endproperty
  property p_ldo;
    s_ovr and pwdata[0]
      |-> ldo_select_1v8 == pwdata[1] ##1 $stable(ldo_select_1v8);
  endproperty
  property p_sdio;
    s_ovr and pwdata[2]
      |-> {sdio_input_rising, sdio_output_rising} == pwdata[4:3]
      ##1 $stable({sdio_input_rising, sdio_output_rising});
  endproperty

  a_wait: assert property (p_wait) else $error("pready late");
  a_err: assert property (p_err) else $error("bad error");
  a_boot: assert property (p_boot) else $error("bad boot");
  a_pon: assert property (p_pon) else $error("pulls off");
  a_poff: assert property (p_poff) else $error("pulls on");
  a_hold: assert property (p_hold) else $error("latch moved");
  a_start: assert property (p_start) else $error("no capture");
  a_dis: assert property (p_dis) else $error("enable ignored");
  a_ldo: assert property (p_ldo) else $error("ldo ovr");
  a_sdio: assert property (p_sdio) else $error("sdio ovr");
endmodule

bind sblc_top sblc_top_monitor u_mon (.*);

`default_nettype wire

// ---- bench/test_strap_latch_boot_config.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_strap_latch_boot_config;
  logic pclk = 0, presetn = 0, module_enable = 1, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, strap_role, boot_done;
  logic ldo_select_1v8, uart0_log_enable, sdio_input_rising;
  logic sdio_output_rising;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [4:0] strap_pull_up_en, strap_pull_down_en, pins;
  logic [4:0] drv_en = 0, drv_val = 0;
  logic [1:0] boot_source;
  logic [19:0] lfsr_q = 20'h1_5ebc;
  int n_mismatch = 0, comparisons = 0, cyc = 0, strap_m, ovr;
  wire logic ldo_voltage_strap = pins[0];
  wire logic primary_boot_strap = pins[1];
  wire logic secondary_boot_strap = pins[2];
  wire logic log_and_timing_strap = pins[3];
  wire logic sdio_timing_strap = pins[4];

  sblc_top dut (.*);
  sblc_board u_board (.pclk(pclk), .pull_up(strap_pull_up_en),
    .pull_dn(strap_pull_down_en), .drv_en(drv_en), .drv_val(drv_val),
    .pins(pins));

  // Free-running bus clock and the hang limit.
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------
  function automatic logic [19:0] rnd();
    lfsr_q = {lfsr_q[18:0], lfsr_q[19] ^ lfsr_q[16]};
    return lfsr_q;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer; the answer is taken at the edge pready is high.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [31:0] e, logic er);
    int t;
    logic [31:0] rd;
    logic se;
    t = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 40);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    chk("pslverr", er, se);
    if (!w) chk("prdata", e, rd);
  endtask

  // Outputs expected from the latched straps and the override word.
  task automatic outs();
    chk("source", strap_m[1] ? 1 : strap_m[2] ? 3 : 2, boot_source);
    chk("ldo", ovr[0] ? ovr[1] : strap_m[0], ldo_select_1v8);
    chk("log", strap_m[3], uart0_log_enable);
    chk("sdio", ovr[2] ? ovr[4:3] : {strap_m[3], strap_m[4]},
        {sdio_input_rising, sdio_output_rising});
    chk("role", 0, {strap_role, strap_pull_up_en, strap_pull_down_en});
  endtask

  // Waits for capture, then checks decodes and the status words.
  task automatic settle(int en, int s);
    int t;
    t = 0;
    while (boot_done !== 1'b1 && t < 40) begin
      @(negedge pclk);
      t++;
    end
    strap_m = (s & en & 'h1e) | (~en & 'h1a);
    ovr = 0;
    chk("done", 1, boot_done);
    outs();
    apb(0, 12'h000, 0, strap_m, 0);
    apb(0, 12'h008, 0, 8 | (strap_m[1] ? 1 : strap_m[2] ? 3 : 2), 0);
    drv_en <= 5'(rnd());
    drv_val <= 5'(rnd());
    repeat (6) @(posedge pclk);
    apb(0, 12'h000, 0, strap_m, 0);
  endtask

  task automatic start(int en, int s);
    drv_en <= 5'(en);
    drv_val <= 5'(s);
    presetn <= 0;
    repeat (16) @(posedge pclk);
    chk("pulls", 'h345, {strap_pull_up_en, strap_pull_down_en});
    presetn <= 1;
    apb(1, 12'h004, 'h1f, 0, 0);
    apb(0, 12'h004, 0, 0, 0);
    settle(en, s);
  endtask

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    start(0, 0);
    for (int k = 0; k < 16; k++) start('h1f, k << 1);
    for (int i = 0; i < 8; i++) begin
      ovr = i == 0 ? 'h1f : rnd() & 'h1f;
      apb(1, 12'h004, ovr, 0, 0);
      repeat (2) @(posedge pclk);
      outs();
      apb(0, 12'h004, 0, ovr, 0);
    end
    apb(1, 12'h000, 'hffff_ffff, 0, 0);
    apb(0, 12'h000, 0, strap_m, 0);
    apb(0, 12'h00c, 0, 0, 1);
    apb(1, 12'h00c, 'h1, 0, 1);
    apb(1, 12'h004, 0, 0, 0);
    module_enable <= 0;
    repeat (5) @(posedge pclk);
    chk("off", 'hb45, {strap_role, boot_done, strap_pull_up_en,
        strap_pull_down_en});
    drv_en <= 'h1f;
    drv_val <= 'h14;
    repeat (4) @(posedge pclk);
    module_enable <= 1;
    settle('h1f, 'h14);
    tally_and_finish();
  end
endmodule

`default_nettype wire
